//--- common/fpec_pkg.sv
// shared constants and types for the serial flash program/erase command logic
package fpec_pkg;
	// =====================================================================
	// opcodes
	localparam logic [7:0] OPC_WRITE_LATCH_SET = 8'h06;
	localparam logic [7:0] OPC_ARRAY_ERASE = 8'h60;
	localparam logic [7:0] OPC_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OPC_QUAD_PAGE_WRITE = 8'h38;
	localparam logic [7:0] OPC_DEEP_SLEEP = 8'hb9;
	localparam logic [7:0] OPC_DEEP_SLEEP_RELEASE = 8'hab;
	localparam logic [7:0] OPC_SIGNATURE_READ = 8'hab;
	localparam logic [7:0] OPC_SOFT_RESET = 8'h99;
	localparam logic [7:0] OPC_WIDE_ADDRESS_ENTER = 8'hb7;
	localparam logic [7:0] OPC_OTP_REGION_ENTER = 8'hb1;
	localparam logic [7:0] OPC_OTP_REGION_EXIT = 8'hc1;
	// =====================================================================
	// timing
	localparam int CLK_MHZ = 125;
	localparam int ARRAY_ERASE_TIME_US = 50000;
	localparam int PAGE_WRITE_TIME_US = 500;
	localparam int SLEEP_ENTRY_DELAY_US = 10;
	localparam int ARRAY_ERASE_CYC = ARRAY_ERASE_TIME_US * CLK_MHZ;
	localparam int PAGE_WRITE_CYC = PAGE_WRITE_TIME_US * CLK_MHZ;
	localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_DELAY_US * CLK_MHZ;
	localparam logic [2:0] LINK_HALF_CYC = 3'h5;
	// =====================================================================
	// geometry
	localparam logic [2:0] ADDR_BYTES_NARROW = 3'h3;
	localparam logic [2:0] ADDR_BYTES_WIDE = 3'h4;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int PAGE_BYTES = 256;
	// =====================================================================
	// frame phases of the device end
	typedef enum logic [3:0] {
		FPEC_PH_OPC = 4'b0001,
		FPEC_PH_ADDR = 4'b0010,
		FPEC_PH_DATA = 4'b0100,
		FPEC_PH_SKIP = 4'b1000
	} fpec_phase_t;
	// internal jobs of the device end
	typedef enum logic [3:0] {
		FPEC_JOB_IDLE = 4'b0001,
		FPEC_JOB_PROG = 4'b0010,
		FPEC_JOB_ERASE = 4'b0100,
		FPEC_JOB_SLEEP = 4'b1000
	} fpec_job_t;
	// host sequencer states
	typedef enum logic [5:0] {
		FPEC_H_IDLE = 6'b000001,
		FPEC_H_LEAD = 6'b000010,
		FPEC_H_HIGH = 6'b000100,
		FPEC_H_LOW = 6'b001000,
		FPEC_H_TRAIL = 6'b010000,
		FPEC_H_GAP = 6'b100000
	} fpec_hstate_t;
endpackage

//--- common/fpec_link_if.sv
// serial link between host controller and flash device
`timescale 1ns/10ps
interface fpec_link_if;
	logic cs_n;
	logic sclk;
	logic [3:0] sio_o;
	logic [3:0] sio_oe;
	logic [3:0] serial_io_line;
	// =====================================================================
	// resolved data lines, pulled high when undriven
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			serial_io_line[i] = sio_oe[i] ? sio_o[i] : 1'b1;
		end
	end
	modport host (output cs_n, output sclk, output sio_o, output sio_oe);
	modport dev (input cs_n, input sclk, input serial_io_line);
endinterface

//--- src/fpec_dev.sv
// flash device end: command decode, page buffer and self-timed cycles
`timescale 1ns/10ps
module fpec_dev #(
	parameter int ARRAY_ERASE_CYC = fpec_pkg::ARRAY_ERASE_CYC,
	parameter int PAGE_WRITE_CYC = fpec_pkg::PAGE_WRITE_CYC,
	parameter int SLEEP_ENTRY_CYC = fpec_pkg::SLEEP_ENTRY_CYC
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	fpec_link_if.dev link,
	input wire logic quad_command_protocol_i,
	input wire logic quad_lines_enable_i,
	input wire logic protect_scheme_select_i,
	input wire logic [3:0] region_lock_bits_i,
	input wire logic page_locked_i,
	input wire logic otp_locked_i,
	output logic op_in_progress_flag_o,
	output logic write_latch_o,
	output logic deep_sleep_o,
	output logic otp_mode_o,
	output logic wide_address_o,
	output logic [31:0] target_addr_o,
	output logic mem_wr_o,
	output logic [31:0] mem_addr_o,
	output logic [7:0] mem_data_o,
	output logic mem_erase_o,
	output logic mem_erase_skip_o
);
	localparam logic [31:0] ERASE_LAST = 32'(ARRAY_ERASE_CYC - 1);
	localparam logic [31:0] PROG_LAST = 32'(PAGE_WRITE_CYC - 1);
	localparam logic [31:0] SLEEP_LAST = 32'(SLEEP_ENTRY_CYC - 1);
	localparam logic [31:0] PAGE_LEN = 32'(fpec_pkg::PAGE_BYTES);

	typedef struct packed {
		logic sclk_m;
		logic sclk_s;
		logic sclk_d;
		logic cs_m;
		logic cs_s;
		logic cs_d;
		logic [3:0] sio_m;
		logic [3:0] sio_s;
		fpec_pkg::fpec_phase_t phase;
		fpec_pkg::fpec_job_t job;
		logic [7:0] op;
		logic [7:0] sh;
		logic [3:0] nbit;
		logic [2:0] abytes;
		logic [31:0] addr;
		logic [7:0] col;
		logic have_data;
		logic extra;
		logic [255:0] mask;
		logic busy;
		logic latch;
		logic sleep;
		logic otp;
		logic wide;
		logic [31:0] tmr;
		logic mem_wr;
		logic [31:0] mem_addr;
		logic [7:0] mem_data;
		logic mem_erase;
		logic mem_skip;
	} fpec_dev_state_t;

	fpec_dev_state_t s;
	fpec_dev_state_t next_s;
	logic [7:0] pbuf [0:255];
	logic buf_we;
	logic [7:0] buf_idx;
	logic [7:0] buf_din;

	// =====================================================================
	// frame capture, command decode and internal cycles
	always_comb begin
		logic rise;
		logic cs_fall;
		logic cs_rise;
		logic w4;
		logic [7:0] shv;
		logic [3:0] nb;
		logic ok1;
		logic okpp;
		rise = 1'b0;
		cs_fall = 1'b0;
		cs_rise = 1'b0;
		w4 = 1'b0;
		shv = 8'h00;
		nb = 4'h0;
		ok1 = 1'b0;
		okpp = 1'b0;
		next_s = s;
		buf_we = 1'b0;
		buf_idx = s.col;
		buf_din = 8'h00;
		next_s.mem_wr = 1'b0;
		next_s.mem_erase = 1'b0;
		// two-stage synchronisers on every link input
		next_s.sclk_m = link.sclk;
		next_s.sclk_s = s.sclk_m;
		next_s.sclk_d = s.sclk_s;
		next_s.cs_m = link.cs_n;
		next_s.cs_s = s.cs_m;
		next_s.cs_d = s.cs_s;
		next_s.sio_m = link.serial_io_line;
		next_s.sio_s = s.sio_m;
		rise = s.sclk_s & ~s.sclk_d;
		cs_fall = ~s.cs_s & s.cs_d;
		cs_rise = s.cs_s & ~s.cs_d;
		// opcode width follows protocol, quad page write data on four lines
		w4 = (s.phase == fpec_pkg::FPEC_PH_OPC) ? quad_command_protocol_i :
			(quad_command_protocol_i | (s.op == fpec_pkg::OPC_QUAD_PAGE_WRITE));
		shv = w4 ? {s.sh[3:0], s.sio_s} : {s.sh[6:0], s.sio_s[0]};
		nb = s.nbit + (w4 ? 4'h4 : 4'h1);
		if (cs_fall) begin
			next_s.phase = fpec_pkg::FPEC_PH_OPC;
			next_s.op = 8'h00;
			next_s.nbit = 4'h0;
			next_s.abytes = 3'h0;
			next_s.have_data = 1'b0;
			next_s.extra = 1'b0;
			if (s.job == fpec_pkg::FPEC_JOB_IDLE) begin
				next_s.mask = '0;
				next_s.addr = 32'h0; // a running program still needs its page address
			end
		end else if (~s.cs_s && rise) begin
			if (s.phase == fpec_pkg::FPEC_PH_SKIP) begin
				next_s.extra = 1'b1;
			end else if (nb == fpec_pkg::BYTE_BITS) begin
				next_s.nbit = 4'h0;
				unique case (s.phase)
					fpec_pkg::FPEC_PH_OPC: begin
						next_s.op = shv;
						next_s.phase = fpec_pkg::FPEC_PH_SKIP;
						if (shv == fpec_pkg::OPC_PAGE_WRITE) begin
							next_s.phase = fpec_pkg::FPEC_PH_ADDR;
						end
						if (shv == fpec_pkg::OPC_QUAD_PAGE_WRITE && quad_lines_enable_i &&
							~quad_command_protocol_i) begin
							next_s.phase = fpec_pkg::FPEC_PH_ADDR;
						end
					end
					fpec_pkg::FPEC_PH_ADDR: begin
						next_s.addr = (s.job == fpec_pkg::FPEC_JOB_IDLE) ? {s.addr[23:0], shv} : s.addr;
						next_s.abytes = s.abytes + 3'h1;
						next_s.col = shv;
						if (s.abytes + 3'h1 == (s.wide ? fpec_pkg::ADDR_BYTES_WIDE :
							fpec_pkg::ADDR_BYTES_NARROW)) begin
							next_s.phase = fpec_pkg::FPEC_PH_DATA;
						end
					end
					fpec_pkg::FPEC_PH_DATA: begin
						if (s.job == fpec_pkg::FPEC_JOB_IDLE) begin
							buf_we = 1'b1;
							buf_din = shv;
							next_s.mask[s.col] = 1'b1;
							next_s.col = s.col + 8'h01;
							next_s.have_data = 1'b1;
						end
					end
					fpec_pkg::FPEC_PH_SKIP: begin
						next_s.extra = 1'b1;
					end
				endcase
			end else begin
				next_s.nbit = nb;
				next_s.sh = shv;
			end
		end
		// frame end: opcode-only commands need exact byte boundary
		ok1 = (s.phase == fpec_pkg::FPEC_PH_SKIP) && ~s.extra;
		okpp = (s.phase == fpec_pkg::FPEC_PH_DATA) && (s.nbit == 4'h0) && s.have_data;
		if (cs_rise && s.sleep) begin
			if (ok1 && (s.op == fpec_pkg::OPC_DEEP_SLEEP_RELEASE ||
				s.op == fpec_pkg::OPC_SIGNATURE_READ)) begin
				next_s.sleep = 1'b0;
			end
			if (ok1 && s.op == fpec_pkg::OPC_SOFT_RESET) begin
				next_s.sleep = 1'b0;
				next_s.latch = 1'b0;
				next_s.otp = 1'b0;
				next_s.wide = 1'b0;
			end
		end else if (cs_rise && s.job == fpec_pkg::FPEC_JOB_IDLE) begin
			if (ok1) begin
				unique case (s.op)
					fpec_pkg::OPC_WRITE_LATCH_SET: next_s.latch = 1'b1;
					fpec_pkg::OPC_WIDE_ADDRESS_ENTER: next_s.wide = 1'b1;
					fpec_pkg::OPC_OTP_REGION_ENTER: next_s.otp = 1'b1;
					fpec_pkg::OPC_OTP_REGION_EXIT: next_s.otp = 1'b0;
					fpec_pkg::OPC_SOFT_RESET: begin
						next_s.latch = 1'b0;
						next_s.otp = 1'b0;
						next_s.wide = 1'b0;
					end
					fpec_pkg::OPC_DEEP_SLEEP: begin
						next_s.job = fpec_pkg::FPEC_JOB_SLEEP;
						next_s.tmr = 32'h0;
					end
					fpec_pkg::OPC_ARRAY_ERASE: begin
						// refused erase keeps the latch and stays idle
						if (s.latch && ~s.otp && (protect_scheme_select_i || region_lock_bits_i == 4'h0)) begin
							next_s.job = fpec_pkg::FPEC_JOB_ERASE;
							next_s.busy = 1'b1;
							next_s.tmr = 32'h0;
							next_s.mem_erase = 1'b1;
							next_s.mem_skip = protect_scheme_select_i;
						end
					end
					default: begin
					end
				endcase
			end else if (okpp && s.latch) begin
				if (s.otp ? ~otp_locked_i : ~page_locked_i) begin
					next_s.job = fpec_pkg::FPEC_JOB_PROG;
					next_s.busy = 1'b1;
					next_s.tmr = 32'h0;
				end
			end
		end
		// self-timed cycles; program streams the page buffer out first
		unique case (s.job)
			fpec_pkg::FPEC_JOB_IDLE: begin
			end
			fpec_pkg::FPEC_JOB_PROG: begin
				next_s.tmr = s.tmr + 32'h1;
				if (s.tmr < PAGE_LEN && s.mask[s.tmr[7:0]]) begin
					next_s.mem_wr = 1'b1;
					next_s.mem_addr = {s.addr[31:8], s.tmr[7:0]};
					next_s.mem_data = pbuf[s.tmr[7:0]];
				end
				if (s.tmr == PROG_LAST) begin
					next_s.job = fpec_pkg::FPEC_JOB_IDLE;
					next_s.busy = 1'b0;
					next_s.latch = 1'b0;
				end
			end
			fpec_pkg::FPEC_JOB_ERASE: begin
				next_s.tmr = s.tmr + 32'h1;
				if (s.tmr == ERASE_LAST) begin
					next_s.job = fpec_pkg::FPEC_JOB_IDLE;
					next_s.busy = 1'b0;
					next_s.latch = 1'b0;
				end
			end
			fpec_pkg::FPEC_JOB_SLEEP: begin
				next_s.tmr = s.tmr + 32'h1;
				if (s.tmr == SLEEP_LAST) begin
					next_s.job = fpec_pkg::FPEC_JOB_IDLE;
					next_s.sleep = 1'b1;
				end
			end
		endcase
	end

	// =====================================================================
	// state register; power-up never lands in sleep
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s <= '0;
			s.sclk_m <= 1'b0;
			s.cs_m <= 1'b1;
			s.cs_s <= 1'b1;
			s.cs_d <= 1'b1;
			s.phase <= fpec_pkg::FPEC_PH_SKIP;
			s.job <= fpec_pkg::FPEC_JOB_IDLE;
			s.sleep <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// page buffer, written by column so later bytes overwrite earlier ones
	always_ff @(posedge sys_clk_i) begin
		if (buf_we) begin
			pbuf[buf_idx] <= buf_din;
		end
	end

	// =====================================================================
	// outputs straight from state
	assign op_in_progress_flag_o = s.busy;
	assign write_latch_o = s.latch;
	assign deep_sleep_o = s.sleep;
	assign otp_mode_o = s.otp;
	assign wide_address_o = s.wide;
	assign target_addr_o = s.addr;
	assign mem_wr_o = s.mem_wr;
	assign mem_addr_o = s.mem_addr;
	assign mem_data_o = s.mem_data;
	assign mem_erase_o = s.mem_erase;
	assign mem_erase_skip_o = s.mem_skip;
endmodule // fpec_dev

//--- src/fpec_host.sv
// host controller end: frames opcode, address and data onto the serial link
`timescale 1ns/10ps
module fpec_host (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	fpec_link_if.host link,
	input wire logic start_i,
	input wire logic [7:0] opcode_i,
	input wire logic [31:0] addr_i,
	input wire logic [2:0] addr_bytes_i,
	input wire logic [9:0] data_count_i,
	input wire logic quad_cmd_i,
	input wire logic quad_data_i,
	input wire logic [7:0] data_i,
	output logic data_take_o,
	output logic busy_o,
	output logic done_o
);
	typedef struct packed {
		fpec_pkg::fpec_hstate_t st;
		logic [2:0] hc;
		logic sclk;
		logic cs_n;
		logic [7:0] sh;
		logic [2:0] kc;
		logic w4;
		logic [10:0] cnt;
		logic [10:0] total;
		logic [31:0] addr;
		logic [2:0] naddr;
		logic qcmd;
		logic qdata;
		logic [3:0] sio_o;
		logic [3:0] sio_oe;
		logic take;
		logic busy;
		logic done;
	} fpec_host_state_t;

	fpec_host_state_t s;
	fpec_host_state_t next_s;

	// =====================================================================
	// sequencer: divider makes the link clock, data changes on falling edge
	always_comb begin
		logic tick;
		logic [10:0] nidx;
		logic [2:0] back;
		tick = (s.hc == fpec_pkg::LINK_HALF_CYC - 3'h1);
		nidx = s.cnt + 11'h1;
		back = s.naddr - nidx[2:0];
		next_s = s;
		next_s.take = 1'b0;
		next_s.done = 1'b0;
		next_s.hc = tick ? 3'h0 : s.hc + 3'h1;
		unique case (s.st)
			fpec_pkg::FPEC_H_IDLE: begin
				next_s.hc = 3'h0;
				if (start_i) begin
					next_s.st = fpec_pkg::FPEC_H_LEAD;
					next_s.cs_n = 1'b0;
					next_s.busy = 1'b1;
					next_s.sh = opcode_i;
					next_s.w4 = quad_cmd_i;
					next_s.kc = quad_cmd_i ? 3'h1 : 3'h7;
					next_s.cnt = 11'h0;
					next_s.total = 11'h1 + 11'(addr_bytes_i) + 11'(data_count_i);
					next_s.addr = addr_i;
					next_s.naddr = addr_bytes_i;
					next_s.qcmd = quad_cmd_i;
					next_s.qdata = quad_data_i & ~quad_cmd_i;
				end
			end
			fpec_pkg::FPEC_H_LEAD, fpec_pkg::FPEC_H_LOW: begin
				if (tick) begin
					next_s.sclk = 1'b1;
					next_s.st = fpec_pkg::FPEC_H_HIGH;
				end
			end
			fpec_pkg::FPEC_H_HIGH: begin
				if (tick) begin
					next_s.sclk = 1'b0;
					next_s.st = fpec_pkg::FPEC_H_LOW;
					if (s.kc != 3'h0) begin
						next_s.kc = s.kc - 3'h1;
						next_s.sh = s.w4 ? {s.sh[3:0], 4'h0} : {s.sh[6:0], 1'b0};
					end else if (nidx == s.total) begin
						next_s.st = fpec_pkg::FPEC_H_TRAIL;
					end else begin
						// next byte: address most significant first, then data
						next_s.cnt = nidx;
						next_s.w4 = s.qcmd | s.qdata;
						next_s.kc = (s.qcmd | s.qdata) ? 3'h1 : 3'h7;
						if (nidx <= 11'(s.naddr)) begin
							next_s.sh = 8'(s.addr >> {back, 3'h0});
						end else begin
							next_s.sh = data_i;
							next_s.take = 1'b1;
						end
					end
				end
			end
			fpec_pkg::FPEC_H_TRAIL: begin
				if (tick) begin
					next_s.cs_n = 1'b1;
					next_s.st = fpec_pkg::FPEC_H_GAP;
				end
			end
			fpec_pkg::FPEC_H_GAP: begin
				if (tick) begin
					next_s.st = fpec_pkg::FPEC_H_IDLE;
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
				end
			end
		endcase
		// line drive follows the byte being shifted
		next_s.sio_o = next_s.w4 ? next_s.sh[7:4] : {3'h0, next_s.sh[7]};
		next_s.sio_oe = next_s.cs_n ? 4'h0 : (next_s.w4 ? 4'hf : 4'h1);
	end

	// =====================================================================
	// state register
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s <= '0;
			s.st <= fpec_pkg::FPEC_H_IDLE;
			s.cs_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign link.cs_n = s.cs_n;
	assign link.sclk = s.sclk;
	assign link.sio_o = s.sio_o;
	assign link.sio_oe = s.sio_oe;
	assign data_take_o = s.take;
	assign busy_o = s.busy;
	assign done_o = s.done;
endmodule // fpec_host

//--- sim/fpec_chk.sv
// assertion checker for the flash command link and device end
`timescale 1ns/10ps
module fpec_chk #(
	parameter int PAGE_WRITE_CYC = 300,
	parameter int ARRAY_ERASE_CYC = 400
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic op_in_progress_flag_o,
	input wire logic write_latch_o,
	input wire logic deep_sleep_o,
	input wire logic otp_mode_o,
	input wire logic wide_address_o,
	input wire logic mem_wr_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic mem_erase_o,
	input wire logic mem_erase_skip_o,
	input wire logic protect_scheme_select_i,
	input wire logic [3:0] region_lock_bits_i
);
	int busy_len;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// =====================================================================
	// length of the current busy stretch
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_len <= 0;
		end else begin
			busy_len <= op_in_progress_flag_o ? busy_len + 1 : 0;
		end
	end
	// =====================================================================
	// assertions
	a_busy_length: assert property ($fell(op_in_progress_flag_o) |->
		busy_len == PAGE_WRITE_CYC || busy_len == ARRAY_ERASE_CYC) else $error("busy length wrong");
	a_latch_clears: assert property ($fell(op_in_progress_flag_o) |-> $fell(write_latch_o)) else $error("latch kept");
	a_busy_needs_latch: assert property ($rose(op_in_progress_flag_o) |-> write_latch_o) else $error("no latch");
	a_erase_first: assert property (mem_erase_o |-> $rose(op_in_progress_flag_o)) else $error("erase late");
	a_erase_locks: assert property (mem_erase_o |->
		protect_scheme_select_i || region_lock_bits_i == 4'h0) else $error("locked erase");
	a_erase_skip: assert property (mem_erase_o |-> mem_erase_skip_o == protect_scheme_select_i) else $error("skip");
	a_write_busy: assert property (mem_wr_o |-> op_in_progress_flag_o && !mem_erase_o) else $error("write idle");
	a_sleep_still: assert property (deep_sleep_o && $past(deep_sleep_o) |->
		!$rose(op_in_progress_flag_o) && $stable(write_latch_o)) else $error("sleep acted");
	a_otp_no_erase: assert property (mem_erase_o |-> !otp_mode_o) else $error("otp erase");
	a_narrow_addr: assert property (mem_wr_o && !wide_address_o |-> mem_addr_o[31:24] == 8'h00) else $error("addr");
	a_idle_clock: assert property (cs_n |-> !sclk) else $error("clock outside frame");
	// =====================================================================
	// covers
	c_erase_skip: cover property (mem_erase_o && mem_erase_skip_o);
	c_write: cover property (mem_wr_o);
	c_sleep: cover property ($rose(deep_sleep_o));
endmodule // fpec_chk

//--- sim/test_flash_program_erase_cmds.sv
// self-checking bench: host end drives device end over the serial link
`timescale 1ns/10ps
module test_flash_program_erase_cmds;
	localparam int PW = 300;
	localparam int AE = 400;
	localparam logic [7:0] WLS = fpec_pkg::OPC_WRITE_LATCH_SET;
	localparam logic [7:0] PGW = fpec_pkg::OPC_PAGE_WRITE;
	localparam logic [7:0] ERA = fpec_pkg::OPC_ARRAY_ERASE;
	logic sys_clk_i, sys_rst_i, start, qc, qd, take, hbusy, done;
	logic qle, pss, pl, ol, op, wl, ds, om, wa, mw, me, mes, bs, es, sk;
	logic [7:0] opc, din, md;
	logic [31:0] addr, ta, ma, seed;
	logic [2:0] ab;
	logic [9:0] cnt;
	logic [3:0] rlb;
	logic [39:0] got[$], exq[$];
	logic [7:0] dq[$];
	int failures, num_checks;
	fpec_link_if lnk();
	fpec_host i_fpec_host (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link(lnk), .start_i(start),
		.opcode_i(opc), .addr_i(addr), .addr_bytes_i(ab), .data_count_i(cnt), .quad_cmd_i(qc),
		.quad_data_i(qd), .data_i(din), .data_take_o(take), .busy_o(hbusy), .done_o(done));
	fpec_dev #(.ARRAY_ERASE_CYC(AE), .PAGE_WRITE_CYC(PW), .SLEEP_ENTRY_CYC(10)) i_fpec_dev (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link(lnk), .quad_command_protocol_i(qc),
		.quad_lines_enable_i(qle), .protect_scheme_select_i(pss), .region_lock_bits_i(rlb),
		.page_locked_i(pl), .otp_locked_i(ol), .op_in_progress_flag_o(op), .write_latch_o(wl),
		.deep_sleep_o(ds), .otp_mode_o(om), .wide_address_o(wa), .target_addr_o(ta), .mem_wr_o(mw),
		.mem_addr_o(ma), .mem_data_o(md), .mem_erase_o(me), .mem_erase_skip_o(mes));
	fpec_chk #(.PAGE_WRITE_CYC(PW), .ARRAY_ERASE_CYC(AE)) i_fpec_chk (.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i), .cs_n(lnk.cs_n), .sclk(lnk.sclk), .op_in_progress_flag_o(op),
		.write_latch_o(wl), .deep_sleep_o(ds), .otp_mode_o(om), .wide_address_o(wa), .mem_wr_o(mw),
		.mem_addr_o(ma), .mem_erase_o(me), .mem_erase_skip_o(mes), .protect_scheme_select_i(pss),
		.region_lock_bits_i(rlb));
	// =====================================================================
	// clock and watchdog
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#(95000 * 8);
		failures++;
		final_report();
	end
	// collect array writes, busy and erase events mid-cycle, where the pulses have settled
	always @(negedge sys_clk_i) begin
		if (mw === 1'b1) got.push_back({ma, md});
		if (op === 1'b1) bs = 1'b1;
		if (me === 1'b1) begin
			es = 1'b1;
			sk = mes;
		end
	end
	// =====================================================================
	// helpers
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one host transfer, then wait for the device cycle to finish
	task automatic cmd(input logic [7:0] o, input logic [31:0] a, input logic [2:0] b, input int n);
		int k;
		int t;
		dq.delete();
		got.delete();
		exq.delete();
		for (k = 0; k < n; k++) dq.push_back(rnd());
		bs = 1'b0;
		es = 1'b0;
		sk = 1'b0;
		opc = o;
		addr = a;
		ab = b;
		cnt = n[9:0];
		din = (n > 0) ? dq[0] : 8'h00;
		start = 1'b1;
		@(posedge sys_clk_i);
		#1;
		start = 1'b0;
		k = 1;
		for (t = 0; t < 30000 && done !== 1'b1; t++) begin
			if (take === 1'b1) begin
				din = (k < n) ? dq[k] : 8'h00;
				k++;
			end
			@(posedge sys_clk_i);
			#1;
		end
		chk({done, hbusy}, 2'b10);
		repeat (20) @(posedge sys_clk_i);
		#1;
		for (t = 0; t < 600 && op !== 1'b0; t++) begin
			@(posedge sys_clk_i);
			#1;
		end
		chk(op, 1'b0);
	endtask
	// page model: columns wrap, later bytes overwrite, written in column order
	task automatic exp_page(input logic [31:0] a);
		logic [7:0] v[256];
		bit h[256];
		int i;
		for (i = 0; i < dq.size(); i++) begin
			v[(a[7:0] + i) % 256] = dq[i];
			h[(a[7:0] + i) % 256] = 1'b1;
		end
		for (i = 0; i < 256; i++) if (h[i]) exq.push_back({a[31:8], i[7:0], v[i]});
		chk(got.size(), exq.size());
		for (i = 0; i < exq.size() && i < got.size(); i++) chk(got[i], exq[i]);
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// =====================================================================
	// main sequence
	initial begin
		{start, qc, qd, qle, pss, pl, ol, opc, din, addr, ab, cnt, rlb} = '0;
		{bs, es, sk} = 3'h0;
		seed = 32'h00000045;
		failures = 0;
		num_checks = 0;
		sys_rst_i = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		#1;
		sys_rst_i = 1'b0;
		repeat (5) @(posedge sys_clk_i);
		#1;
		chk(ds, 1'b0);
		cmd(PGW, 32'h1200, 3'h3, 2);
		chk(bs, 1'b0);
		chk(got.size(), 0);
		cmd(WLS, 32'h0, 3'h0, 0);
		chk(wl, 1'b1);
		cmd(PGW, 32'h3fe, 3'h3, 3);
		exp_page(32'h3fe);
		chk(bs, 1'b1);
		chk(wl, 1'b0);
		cmd(WLS, 32'h0, 3'h0, 0);
		cmd(PGW, 32'h500, 3'h3, 258);
		exp_page(32'h500);
		pl = 1'b1;
		cmd(WLS, 32'h0, 3'h0, 0);
		cmd(PGW, 32'h600, 3'h3, 1);
		chk(bs, 1'b0);
		chk(wl, 1'b1);
		pl = 1'b0;
		rlb = 4'(rnd()) | 4'h1;
		cmd(ERA, 32'h0, 3'h0, 0);
		chk(es, 1'b0);
		chk(wl, 1'b1);
		rlb = 4'h0;
		cmd(ERA, 32'h0, 3'h0, 0);
		chk({es, sk, wl}, 3'b100);
		pss = 1'b1;
		rlb = 4'(rnd()) | 4'h1;
		cmd(WLS, 32'h0, 3'h0, 0);
		cmd(ERA, 32'h0, 3'h0, 0);
		chk({es, sk}, 2'b11);
		{pss, rlb, qd} = 6'h01;
		cmd(WLS, 32'h0, 3'h0, 0);
		cmd(fpec_pkg::OPC_QUAD_PAGE_WRITE, 32'h700, 3'h3, 5);
		chk(bs, 1'b0);
		qle = 1'b1;
		cmd(fpec_pkg::OPC_QUAD_PAGE_WRITE, 32'h7f0, 3'h3, 5);
		exp_page(32'h7f0);
		qc = 1'b1;
		cmd(WLS, 32'h0, 3'h0, 0);
		chk(wl, 1'b1);
		cmd(fpec_pkg::OPC_QUAD_PAGE_WRITE, 32'h900, 3'h3, 2);
		chk(bs, 1'b0);
		qd = 1'b0;
		cmd(PGW, 32'h8f0, 3'h3, 4);
		exp_page(32'h8f0);
		qc = 1'b0;
		cmd(fpec_pkg::OPC_WIDE_ADDRESS_ENTER, 32'h0, 3'h0, 0);
		chk(wa, 1'b1);
		cmd(WLS, 32'h0, 3'h0, 0);
		cmd(PGW, 32'h01020300, 3'h4, 2);
		chk(ta, 32'h01020300);
		exp_page(32'h01020300);
		cmd(fpec_pkg::OPC_OTP_REGION_ENTER, 32'h0, 3'h0, 0);
		chk(om, 1'b1);
		cmd(WLS, 32'h0, 3'h0, 0);
		cmd(PGW, 32'h10, 3'h4, 1);
		exp_page(32'h10);
		ol = 1'b1;
		cmd(WLS, 32'h0, 3'h0, 0);
		cmd(PGW, 32'h20, 3'h4, 1);
		chk(bs, 1'b0);
		cmd(fpec_pkg::OPC_OTP_REGION_EXIT, 32'h0, 3'h0, 0);
		chk(om, 1'b0);
		ol = 1'b0;
		cmd(fpec_pkg::OPC_DEEP_SLEEP, 32'h0, 3'h0, 0);
		chk(ds, 1'b1);
		cmd(ERA, 32'h0, 3'h0, 0);
		chk({bs, es}, 2'b00);
		cmd(PGW, 32'h30, 3'h4, 1);
		chk(got.size(), 0);
		cmd(fpec_pkg::OPC_DEEP_SLEEP_RELEASE, 32'h0, 3'h0, 0);
		chk(ds, 1'b0);
		cmd(fpec_pkg::OPC_DEEP_SLEEP, 32'h0, 3'h0, 0);
		cmd(fpec_pkg::OPC_SOFT_RESET, 32'h0, 3'h0, 0);
		chk({ds, wl, wa}, 3'b000);
		// power cycle in mid-run while asleep
		cmd(fpec_pkg::OPC_DEEP_SLEEP, 32'h0, 3'h0, 0);
		chk(ds, 1'b1);
		sys_rst_i = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		#1;
		sys_rst_i = 1'b0;
		repeat (5) @(posedge sys_clk_i);
		#1;
		chk({ds, wl, op}, 3'b000);
		final_report();
	end
endmodule // test_flash_program_erase_cmds
